/* design/amd_pkg.sv */
// Shared constants and types of the amplifier diagnostic status bank
package amd_pkg;

   // Sizes
   localparam int NUM_CHAN    = 4;
   localparam int BYTE_W      = 8;
   localparam int CNT_W       = 4;
   localparam int IDX_W       = 2;

   // Bus address and transfer counts
   localparam logic [6:0]       DEV_ADDR      = 7'h6C;
   localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   localparam logic [IDX_W-1:0] LAST_RD_IDX   = 2'h3;
   localparam logic [IDX_W-1:0] LAST_WR_IDX   = 2'h1;
   localparam logic [IDX_W-1:0] IDX_IB_ONE    = 2'h0;

   // Channel order of the status bytes
   localparam int CH_LEFT_FRONT  = 0;
   localparam int CH_LEFT_REAR   = 1;
   localparam int CH_RIGHT_FRONT = 2;
   localparam int CH_RIGHT_REAR  = 3;

   // Bit positions in the instruction bytes
   localparam int IB1_DIAG_EN_BIT = 6;
   localparam int IB1_OFS_EN_BIT  = 5;
   localparam int IB2_STBY_BIT    = 4;

   // Reset values
   localparam logic [BYTE_W-1:0] IB_RESET = 8'h00;

   // Raw per-channel fault sense from the analog side
   typedef struct packed {
      logic perm_diag;
      logic short_load;
      logic open_load;
      logic offset_det;
      logic short_vcc;
      logic short_gnd;
   } amd_chan_raw_type;

   // Reported per-channel flags, in bit order D4..D0 of a status byte
   typedef struct packed {
      logic perm_diag;
      logic short_load;
      logic open_or_offset;
      logic short_vcc;
      logic short_gnd;
   } amd_chan_flags_type;

   localparam int CHAN_FLAG_W = $bits(amd_chan_flags_type);
   localparam int RAW_W       = NUM_CHAN * $bits(amd_chan_raw_type);

   // Serial bus pins seen from inside
   typedef struct packed {
      logic scl;
      logic sda;
   } amd_pins_type;

   // Serial slave states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK,
      ST_IGNORE
   } amd_state_type;

endpackage

/* design/amd_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module amd_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   import amd_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } amd_sync_state_type;

   amd_sync_state_type st_reg;
   amd_sync_state_type st_next;

   // First stage feeds only the second stage
   always_comb
   begin
      st_next = st_reg;
      if (ce)
      begin
         st_next.s1 = d;
         st_next.s2 = st_reg.s1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign q = st_reg.s2;

endmodule

`default_nettype wire

/* design/amd_fault_cycle.sv */
// Per-channel fault accumulation over one diagnostic cycle, with snapshot
`timescale 1ns/100ps
`default_nettype none

module amd_fault_cycle (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic                        ce,
   input  wire logic                        restart,
   input  wire amd_pkg::amd_chan_flags_type live     [amd_pkg::NUM_CHAN],
   output var  amd_pkg::amd_chan_flags_type result   [amd_pkg::NUM_CHAN]
);
   import amd_pkg::*;

   typedef struct packed {
      logic [NUM_CHAN-1:0][CHAN_FLAG_W-1:0] acc;
      logic [NUM_CHAN-1:0][CHAN_FLAG_W-1:0] snap;
   } amd_cycle_state_type;

   amd_cycle_state_type st_reg;
   amd_cycle_state_type st_next;
   logic [NUM_CHAN-1:0][CHAN_FLAG_W-1:0] acc_nx;
   logic [NUM_CHAN-1:0][CHAN_FLAG_W-1:0] snap_nx;

   // A flag is reported only if it held through the whole cycle; a
   // restart closes the cycle, so a read returns the previous one
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++)
      begin : g_chan
         assign acc_nx[ch]  = restart ? {CHAN_FLAG_W{1'b1}}
                                      : (st_reg.acc[ch] & live[ch]);
         assign snap_nx[ch] = restart ? (st_reg.acc[ch] & live[ch])
                                      : st_reg.snap[ch];
         assign result[ch]  = st_reg.snap[ch];
      end
   endgenerate

   always_comb
   begin
      st_next = st_reg;
      if (ce)
      begin
         st_next.acc  = acc_nx;
         st_next.snap = snap_nx;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

endmodule

`default_nettype wire

/* design/amd_status_bank.sv */
// Serial-bus slave and read-only diagnostic status bank of the amplifier
`timescale 1ns/100ps
`default_nettype none

module amd_status_bank (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      ce,
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output var  logic                      sda_out,
   output var  logic                      sda_oe,
   input  wire logic                      thermal_warn,
   input  wire logic                      diag_cycle_done,
   input  wire amd_pkg::amd_chan_raw_type chan_raw [amd_pkg::NUM_CHAN],
   output var  logic [7:0]                instruction_byte_one,
   output var  logic [7:0]                instruction_byte_two,
   output var  logic                      diag_restart
);
   import amd_pkg::*;

   typedef struct packed {
      amd_state_type     state;
      logic [CNT_W-1:0]  bit_cnt;
      logic [IDX_W-1:0]  byte_idx;
      logic [BYTE_W-1:0] shreg;
      logic              rw;
      logic              ack_ok;
      logic              oe;
      logic [BYTE_W-1:0] ib1;
      logic [BYTE_W-1:0] ib2;
      logic              scl_d;
      logic              sda_d;
      logic              read_active;
      logic              restart;
   } amd_bank_state_type;

   amd_bank_state_type st_reg;
   amd_bank_state_type st_next;

   amd_pins_type       pins_s;
   logic [RAW_W-1:0]   raw_flat;
   logic [RAW_W-1:0]   raw_s;
   logic               therm_s;
   logic               done_s;
   amd_chan_raw_type   raw_chan [NUM_CHAN];
   amd_chan_flags_type live     [NUM_CHAN];
   amd_chan_flags_type result   [NUM_CHAN];
   logic [BYTE_W-1:0]  status   [NUM_CHAN];

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic offset_en;
   logic diag_en;
   logic standby_off;

   // Pins and analog sense come from outside the clock domain
   amd_sync #(
      .W (2)
   ) u_pin_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .d       ({scl_in, sda_in}),
      .q       (pins_s)
   );

   amd_sync #(
      .W (RAW_W + 2)
   ) u_sense_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .d       ({raw_flat, thermal_warn, diag_cycle_done}),
      .q       ({raw_s, therm_s, done_s})
   );

   // Control mirrors taken from the instruction bytes
   assign offset_en   = st_reg.ib1[IB1_OFS_EN_BIT];
   assign diag_en     = st_reg.ib1[IB1_DIAG_EN_BIT];
   assign standby_off = st_reg.ib2[IB2_STBY_BIT];

   // Per-channel flag assembly; bit 2 meaning follows the offset mode
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++)
      begin : g_chan
         localparam int LO = ch * $bits(amd_chan_raw_type);
         assign raw_flat[LO +: $bits(amd_chan_raw_type)] = chan_raw[ch];
         assign raw_chan[ch] = raw_s[LO +: $bits(amd_chan_raw_type)];
         assign live[ch].perm_diag      = raw_chan[ch].perm_diag;
         assign live[ch].short_load     = raw_chan[ch].short_load;
         assign live[ch].open_or_offset = offset_en
                                          ? raw_chan[ch].offset_det
                                          : raw_chan[ch].open_load;
         assign live[ch].short_vcc      = raw_chan[ch].short_vcc;
         assign live[ch].short_gnd      = raw_chan[ch].short_gnd;
      end
   endgenerate

   // Results are frozen per cycle; reads see the closed cycle only
   amd_fault_cycle u_cycle (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .restart (st_reg.restart),
      .live    (live),
      .result  (result)
   );

   // Status bytes in read order; unused upper bits are zero
   assign status[CH_LEFT_FRONT]  = {therm_s,
                                    diag_en & done_s,
                                    1'b0,
                                    result[CH_LEFT_FRONT]};
   assign status[CH_LEFT_REAR]   = {offset_en,
                                    2'b00,
                                    result[CH_LEFT_REAR]};
   assign status[CH_RIGHT_FRONT] = {standby_off,
                                    diag_en,
                                    1'b0,
                                    result[CH_RIGHT_FRONT]};
   assign status[CH_RIGHT_REAR]  = {3'b000,
                                    result[CH_RIGHT_REAR]};

   // Bus events from the synchronised pins
   assign scl_rise   = pins_s.scl & ~st_reg.scl_d;
   assign scl_fall   = ~pins_s.scl & st_reg.scl_d;
   assign start_cond = pins_s.scl & st_reg.scl_d & st_reg.sda_d & ~pins_s.sda;
   assign stop_cond  = pins_s.scl & st_reg.scl_d & ~st_reg.sda_d & pins_s.sda;

   // Serial slave sequencing
   always_comb
   begin
      st_next = st_reg;
      if (ce)
      begin
         // Strobe lasts one enabled cycle; a frozen cycle keeps it as is
         st_next.restart = 1'b0;
         st_next.scl_d = pins_s.scl;
         st_next.sda_d = pins_s.sda;
         if (start_cond || stop_cond)
         begin
            // A read is over at the next start or stop; close the cycle
            st_next.restart     = st_reg.read_active;
            st_next.read_active = 1'b0;
            st_next.oe          = 1'b0;
            st_next.bit_cnt     = '0;
            st_next.state       = start_cond ? ST_ADDR : ST_IDLE;
         end
         else
         begin
            case (st_reg.state)
               ST_IDLE, ST_IGNORE:
               begin
                  st_next.oe = 1'b0;
               end
               ST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     st_next.shreg   = {st_reg.shreg[BYTE_W-2:0], pins_s.sda};
                     st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                  end
                  else if (scl_fall && st_reg.bit_cnt == BITS_PER_BYTE)
                  begin
                     if (st_reg.shreg[BYTE_W-1:1] == DEV_ADDR)
                     begin
                        st_next.rw    = st_reg.shreg[0];
                        st_next.oe    = 1'b1;
                        st_next.state = ST_ADDR_ACK;
                     end
                     else
                        st_next.state = ST_IGNORE;
                  end
               end
               ST_ADDR_ACK:
               begin
                  if (scl_fall)
                  begin
                     st_next.bit_cnt  = '0;
                     st_next.byte_idx = '0;
                     if (st_reg.rw)
                     begin
                        st_next.read_active = 1'b1;
                        st_next.shreg       = status[CH_LEFT_FRONT];
                        st_next.oe          = ~status[CH_LEFT_FRONT][BYTE_W-1];
                        st_next.state       = ST_RD_BYTE;
                     end
                     else
                     begin
                        st_next.oe    = 1'b0;
                        st_next.state = ST_WR_BYTE;
                     end
                  end
               end
               ST_WR_BYTE:
               begin
                  if (scl_rise)
                  begin
                     st_next.shreg   = {st_reg.shreg[BYTE_W-2:0], pins_s.sda};
                     st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                  end
                  else if (scl_fall && st_reg.bit_cnt == BITS_PER_BYTE)
                  begin
                     // Only the two instruction bytes are taken and acknowledged
                     if (st_reg.byte_idx <= LAST_WR_IDX)
                     begin
                        if (st_reg.byte_idx == IDX_IB_ONE)
                           st_next.ib1 = st_reg.shreg;
                        else
                           st_next.ib2 = st_reg.shreg;
                        st_next.oe    = 1'b1;
                        st_next.state = ST_WR_ACK;
                     end
                     else
                        st_next.state = ST_IGNORE;
                  end
               end
               ST_WR_ACK:
               begin
                  if (scl_fall)
                  begin
                     st_next.oe       = 1'b0;
                     st_next.bit_cnt  = '0;
                     st_next.byte_idx = st_reg.byte_idx + 1'b1;
                     st_next.state    = ST_WR_BYTE;
                  end
               end
               ST_RD_BYTE:
               begin
                  if (scl_rise)
                     st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                  else if (scl_fall)
                  begin
                     if (st_reg.bit_cnt == BITS_PER_BYTE)
                     begin
                        // Release the line so the master can acknowledge
                        st_next.oe    = 1'b0;
                        st_next.state = ST_RD_ACK;
                     end
                     else
                     begin
                        st_next.shreg = {st_reg.shreg[BYTE_W-2:0], 1'b0};
                        st_next.oe    = ~st_reg.shreg[BYTE_W-2];
                     end
                  end
               end
               ST_RD_ACK:
               begin
                  if (scl_rise)
                     st_next.ack_ok = ~pins_s.sda && (st_reg.byte_idx != LAST_RD_IDX);
                  else if (scl_fall)
                  begin
                     st_next.bit_cnt = '0;
                     if (st_reg.ack_ok)
                     begin
                        // Next byte in fixed order; never more than four
                        st_next.byte_idx = st_reg.byte_idx + 1'b1;
                        st_next.shreg    = status[st_reg.byte_idx + 1'b1];
                        st_next.oe       = ~status[st_reg.byte_idx + 1'b1][BYTE_W-1];
                        st_next.state    = ST_RD_BYTE;
                     end
                     else
                        st_next.state = ST_IGNORE;
                  end
               end
               default:
               begin
                  st_next.state = ST_IDLE;
                  st_next.oe    = 1'b0;
               end
            endcase
         end
      end
   end

   // Reset values are our own: nothing documented, so all control clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_reg       <= '0;
         st_reg.state <= ST_IDLE;
         st_reg.ib1   <= IB_RESET;
         st_reg.ib2   <= IB_RESET;
         st_reg.scl_d <= 1'b1;
         st_reg.sda_d <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // Open-drain line: only ever pulled low
   assign sda_out              = 1'b0;
   assign sda_oe               = st_reg.oe;
   assign instruction_byte_one = st_reg.ib1;
   assign instruction_byte_two = st_reg.ib2;
   assign diag_restart         = st_reg.restart;

endmodule

`default_nettype wire

/* verification/amd_status_bank_checker.sv */
// Pin-level checks of the diagnostic status bank
`timescale 1ns/100ps
`default_nettype none

module amd_status_bank_checker (
   input wire logic                      clk,
   input wire logic                      sys_rst,
   input wire logic                      ce,
   input wire logic                      scl_in,
   input wire logic                      sda_in,
   input wire logic                      sda_out,
   input wire logic                      sda_oe,
   input wire logic                      thermal_warn,
   input wire logic                      diag_cycle_done,
   input wire amd_pkg::amd_chan_raw_type chan_raw [amd_pkg::NUM_CHAN],
   input wire logic [7:0]                instruction_byte_one,
   input wire logic [7:0]                instruction_byte_two,
   input wire logic                      diag_restart
);
   import amd_pkg::*;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Start condition on the raw input pins
   sequence s_start;
      scl_in && $fell(sda_in);
   endsequence

   // Restart strobe: one clock high, then low
   sequence s_one_pulse;
      diag_restart ##1 !diag_restart;
   endsequence

   a_drive_low_only: assert property (sda_out == 1'b0)
      else $error("data pin output not held low");

   // The device may only move the data line while the clock is low
   a_oe_after_fall: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("data drive changed outside clock low phase");

   a_start_released: assert property (s_start |-> !sda_oe)
      else $error("device drives the line at a start");

   a_restart_pulse: assert property ($rose(diag_restart) |-> s_one_pulse)
      else $error("restart strobe longer than one clock");

   a_restart_at_idle: assert property (diag_restart |-> scl_in && $past(scl_in, 4))
      else $error("restart not at a bus condition");

   a_restart_no_drive: assert property (diag_restart |-> !sda_oe [*4])
      else $error("line driven after a finished read");

   // A read never rewrites the control bytes that the status mirrors
   a_ib_quiet_restart: assert property (diag_restart |->
      $stable({instruction_byte_one, instruction_byte_two}))
      else $error("control bytes moved at read end");

   // Clock enable low freezes every piece of state
   a_ce_freeze: assert property (!ce |=> $stable({instruction_byte_one, instruction_byte_two,
      sda_oe, diag_restart}))
      else $error("state moved while clock enable low");
endmodule

bind amd_status_bank amd_status_bank_checker chk_u (
   .clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .thermal_warn(thermal_warn),
   .diag_cycle_done(diag_cycle_done), .chan_raw(chan_raw),
   .instruction_byte_one(instruction_byte_one),
   .instruction_byte_two(instruction_byte_two), .diag_restart(diag_restart)
);
`default_nettype wire

/* verification/amd_i2c_master.sv */
// Behavioural serial-bus master at the far side of the status bank
`timescale 1ns/100ps
`default_nettype none

module amd_i2c_master (
   input  wire logic clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_low
);
   // 160 ns link period at 4 ns per clock
   localparam int HALF = 20;

   // Idle bus: clock stands high, data left to the pull-up
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Also serves as a repeated start after an ack clock
   task automatic start_bit();
      tick(5);
      sda_low <= 1'b0;
      tick(HALF - 5);
      scl <= 1'b1;
      tick(HALF);
      sda_low <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
   endtask

   // Clock is left standing high afterwards
   task automatic stop_bit();
      tick(5);
      sda_low <= 1'b1;
      tick(HALF - 5);
      scl <= 1'b1;
      tick(HALF);
      sda_low <= 1'b0;
      tick(HALF);
   endtask

   // Data moves early in the low phase; line is sampled mid-high
   task automatic bit_io(input logic b, output logic rb);
      tick(5);
      sda_low <= ~b;
      tick(HALF - 5);
      scl <= 1'b1;
      tick(HALF / 2);
      rb = sda;
      tick(HALF / 2);
      scl <= 1'b0;
   endtask

   // Eight bits MSB first, then the ack slot
   task automatic byte_io(
      input  logic [7:0] tx,
      input  logic       ack_in,
      output logic [7:0] rx,
      output logic       ack
   );
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack);
   endtask
endmodule
`default_nettype wire

/* verification/tb_amp_diag_status_readback.sv */
// Self-checking bench of the diagnostic status bank
`timescale 1ns/100ps
`default_nettype none

module tb_amp_diag_status_readback;
   import amd_pkg::*;
   typedef struct packed {
      logic [7:0]  ib1;
      logic [7:0]  ib2;
      logic        thermal;
      logic        done;
      logic [23:0] raw;
      logic [31:0] exp;
   } amd_tb_row_type;
   // Control bytes, live inputs, raw faults FL RL RF RR, expected status bytes
   localparam amd_tb_row_type ROWS [4] = '{
      '{8'h40, 8'h10, 1'b1, 1'b1, {6'h01, 6'h02, 6'h08, 6'h10}, 32'hC102C408},
      '{8'h20, 8'h00, 1'b0, 1'b1, {6'h24, 6'h08, 6'h3F, 6'h04}, 32'h14801F04},
      '{8'h40, 8'hEF, 1'b0, 1'b0, {6'h00, 6'h00, 6'h00, 6'h3F}, 32'h0000401F},
      '{8'hFF, 8'h10, 1'b1, 1'b1, {6'h3F, 6'h37, 6'h08, 6'h01}, 32'hDF9FC001}};
   localparam logic [31:0] ML = 32'hC080C000; // Live and mirrored bits
   localparam logic [31:0] MZ = 32'h206020E0; // Unused bits
   localparam logic [31:0] MA = 32'h1C1C1C1C; // Bits 4 to 2
   localparam logic [31:0] MB = 32'h03030303; // Bits 1 and 0
   logic             clk;
   logic             sys_rst;
   logic             ce;
   logic             thermal_warn;
   logic             diag_cycle_done;
   amd_chan_raw_type chan_raw [NUM_CHAN];
   logic             sda_out;
   logic             sda_oe;
   logic             diag_restart;
   logic [7:0]       instruction_byte_one;
   logic [7:0]       instruction_byte_two;
   logic             scl_line;
   logic             m_sda_low;
   logic             sda_wire;
   logic [31:0]      ib_word;
   logic [31:0]      got;
   logic [3:0]       nak;
   logic             rd_nak;
   logic [7:0]       rd_extra;
   amd_tb_row_type   r;
   int               fail_count = 0;
   int               comparisons = 0;

   // Open-drain data line with pull-up
   assign sda_wire = ~((sda_oe & ~sda_out) | m_sda_low);
   assign ib_word = {16'h0000, instruction_byte_one, instruction_byte_two};
   always #2 clk = ~clk;

   amd_status_bank dut_u (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_in(scl_line), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .thermal_warn(thermal_warn),
      .diag_cycle_done(diag_cycle_done), .chan_raw(chan_raw),
      .instruction_byte_one(instruction_byte_one),
      .instruction_byte_two(instruction_byte_two), .diag_restart(diag_restart));
   amd_i2c_master master_u (.clk(clk), .sda(sda_wire), .scl(scl_line), .sda_low(m_sda_low));

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %0t word %h, expected %h", $time, g, e);
      end
   endtask

   task automatic chk_ack(input logic [3:0] g, input logic [3:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %0t ack slots %b, expected %b", $time, g, e);
      end
   endtask

   task automatic complete_run();
      $display("Counts: %0d compared, %0d failed", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic set_live(input amd_tb_row_type x);
      @(posedge clk);
      thermal_warn <= x.thermal;
      diag_cycle_done <= x.done;
      for (int c = 0; c < NUM_CHAN; c++)
         chan_raw[c] <= amd_chan_raw_type'(x.raw[23-6*c -: 6]);
      repeat (10) @(posedge clk);
   endtask

   // Address with write direction, then n data bytes; a set bit is a missing ack
   task automatic bus_write(input logic [6:0] a, input logic [23:0] d, input int n,
                            output logic [3:0] nk);
      logic [7:0] rx;
      nk = 4'h0;
      master_u.start_bit();
      master_u.byte_io({a, 1'b0}, 1'b1, rx, nk[0]);
      for (int i = 0; i < n; i++)
         master_u.byte_io(d[23-8*i -: 8], 1'b1, rx, nk[i+1]);
      master_u.stop_bit();
   endtask

   // Four status bytes acked, then a surplus byte clocked and refused
   task automatic bus_read(output logic [31:0] g, output logic nk);
      logic [7:0] rx;
      logic       ack;
      master_u.start_bit();
      master_u.byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, nk);
      for (int i = 0; i < 5; i++)
      begin
         master_u.byte_io(8'hFF, i == 4, rx, ack);
         if (i < 4)
            g[31-8*i -: 8] = rx;
         else
            rd_extra = rx;
      end
      master_u.stop_bit();
   endtask

   task automatic do_reset();
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   // Hang guard
   initial
   begin
      repeat (90000) @(posedge clk);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end

   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      ce = 1'b1;
      thermal_warn = 1'b0;
      diag_cycle_done = 1'b0;
      for (int c = 0; c < NUM_CHAN; c++)
         chan_raw[c] = amd_chan_raw_type'(6'h00);
      do_reset();
      // Table rows: third read shows a cycle with steady inputs
      for (int i = 0; i < 4; i++)
      begin
         r = ROWS[i];
         bus_write(DEV_ADDR, {r.ib1, r.ib2, 8'h00}, 2, nak);
         chk_ack(nak, 4'h0);
         chk_word(ib_word, {16'h0000, r.ib1, r.ib2});
         set_live(r);
         repeat (3) bus_read(got, rd_nak);
         chk_ack({3'h0, rd_nak}, 4'h0);
         chk_word({24'h000000, rd_extra}, 32'h000000FF);
         chk_word(got & ML, r.exp & ML);
         chk_word(got & MZ, r.exp & MZ);
         chk_word(got & MA, r.exp & MA);
         chk_word(got & MB, r.exp & MB);
         $display("Row %0d done", i);
      end
      // Faults removed: first read still shows them, second does not
      r.raw = 24'h000000;
      set_live(r);
      bus_read(got, rd_nak);
      chk_word(got, ROWS[3].exp);
      bus_read(got, rd_nak);
      chk_word(got, 32'hC080C000);
      $display("Stale result test done");
      // Reset mid-run clears control bytes and snapshots
      r.raw = 24'hFFFFFF;
      set_live(r);
      do_reset();
      chk_word(ib_word, 32'h00000000);
      bus_read(got, rd_nak);
      chk_word(got, 32'h80000000);
      $display("Reset test done");
      // Foreign address and a surplus third byte are refused
      bus_write(7'h6D, 24'h401000, 2, nak);
      chk_ack(nak, 4'h7);
      chk_word(ib_word, 32'h00000000);
      bus_write(DEV_ADDR, 24'h4010FF, 3, nak);
      chk_ack(nak, 4'h8);
      chk_word(ib_word, 32'h00004010);
      // Clock enable low: the device ignores the bus
      @(posedge clk);
      ce <= 1'b0;
      bus_write(DEV_ADDR, 24'h000000, 2, nak);
      chk_ack(nak, 4'h7);
      chk_word(ib_word, 32'h00004010);
      ce <= 1'b1;
      $display("Refusal test done");
      complete_run();
   end
endmodule
`default_nettype wire
